/* File: design/serial2_ir_params.svh */
// Purpose: named constants for the second serial port infrared configuration block
// Assumes: APB byte addressing, 40 MHz pclk
// Notes:   definitions only
`ifndef SERIAL2_IR_PARAMS_SVH
`define SERIAL2_IR_PARAMS_SVH
`define REG_IDX_MODE        8'hF0
`define REG_IDX_IROPT       8'hF1
`define REG_IDX_BLANK       8'hF2
`define REG_IDX_SHARE       8'hF3
`define REG_IDX_IRQ_STAT    8'hF4
`define REG_IDX_IRQ_MASK    8'hF5
`define REG_IDX_STATUS      8'hF6
`define MODE_RESET          8'h00
`define IROPT_RESET         8'h02
`define BLANK_RESET         8'h03
`define MODE_MIDI_BIT       0
`define MODE_HS_BIT         1
`define MODE_IDLE_BIT       5
`define MODE_WMASK          8'h23
`define IROPT_RXPOL_BIT     0
`define IROPT_TXPOL_BIT     1
`define IROPT_DUPLEX_BIT    2
`define IROPT_MODE_LSB      3
`define IROPT_MUX_BIT       6
`define IROPT_WMASK         8'h7F
`define IRQ_RX_BLANKED_BIT  0
`define IRQ_BLANK_END_BIT   1
`define IRQ_WIDTH           2
`define BLANK_STEP_NS       100000
`define CLK_PERIOD_NS       25
`endif

/* File: design/serial2_ir_pkg.sv */
// Purpose: types for the second serial port infrared configuration block
// Assumes: nothing beyond the params header
// Notes:   modes and carrier structs
package serial2_ir_pkg;
  typedef enum logic [2:0] {
    IR_MODE_STD  = 3'h0,
    IR_MODE_IRDA = 3'h1,
    IR_MODE_ASK  = 3'h2
  } ir_mode_e;

  typedef struct packed {
    logic rx;
    logic alt_rx;
  } line_in_s;

  typedef struct packed {
    logic tx;
    logic tx_oe;
    logic alt_tx;
    logic alt_tx_oe;
  } line_out_s;

  typedef struct packed {
    logic       tx;
    logic       tx_active;
    logic       rx_active;
    logic [1:0] irq;
  } uart_side_s;
endpackage : serial2_ir_pkg

/* File: design/serial2_infrared_config.sv */
// Purpose: configuration and pin logic for the second serial unit and its infrared option
// Assumes: APB slave on pclk, second serial core and first unit interrupts supplied by the core side
// Notes:   idle-level bit reset only by the standby power-on reset
//
// Behaviour
// - With share bit set, either unit's interrupt drives both interrupt lines.
// - Mode bit 0 enables MIDI support; resets disabled.
// - Mode bit 1 enables high-speed baud; resets disabled.
// - Mode bit 5: zero drives idle normal-pin transmit low, one tristates it; alternate transmit is driven whenever selected.
// - Idle-level bit reset only by standby power-on reset; a mode write sets or clears it.
// - Option bit 0 sets receive polarity; zero active high at reset.
// - Option bit 1 sets transmit polarity; one active low at reset.
// - Option bit 2 selects full duplex zero, half duplex one.
// - Mode field 5:3 selects standard, IrDA or amplitude-keyed infrared.
// - Option bit 6 routes signals to normal or alternate infrared pins.
// - Eight-bit blank time in 100 microsecond steps.
// - Zero blanks only during activity; each step adds 100 microseconds.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "serial2_ir_params.svh"
module serial2_infrared_config #(
  parameter int unsigned STEP_CYCLES = (`BLANK_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire  logic                      pclk,
  input  wire  logic                      presetn,
  input  wire  logic                      standby_por_n,
  input  wire  logic                      psel,
  input  wire  logic                      penable,
  input  wire  logic                      pwrite,
  input  wire  logic [11:0]               paddr,
  input  wire  logic [31:0]               pwdata,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic                            pslverr,
  input  wire  serial2_ir_pkg::uart_side_s core_in,
  input  wire  logic                      first_unit_irq_in,
  input  wire  serial2_ir_pkg::line_in_s  pins_in,
  output serial2_ir_pkg::line_out_s       pins_out,
  output logic                            core_rx_out,
  output logic                            midi_enable,
  output logic                            high_speed_enable,
  output serial2_ir_pkg::ir_mode_e        ir_mode,
  output logic [1:0]                      first_unit_irq_out,
  output logic [1:0]                      second_unit_irq_out,
  output logic                            irq
);
  import serial2_ir_pkg::*;

  // The hold step counter is 16 bits wide, so longer steps cannot be counted
  if (STEP_CYCLES < 1 || STEP_CYCLES > 65535) begin : g_step_check
    $error("STEP_CYCLES out of range");
  end

  // APB access
  logic        acc;
  logic        wr;
  logic [7:0]  idx;
  logic        mapped;
  assign acc    = psel & penable;
  assign wr     = acc & pwrite;
  assign idx    = paddr[9:2];
  assign mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                  (idx >= `REG_IDX_MODE) && (idx <= `REG_IDX_STATUS);

  // No wait states: the answer stands in the access cycle after every setup
  logic        ready_nxt;
  logic        err_nxt;
  assign ready_nxt = psel & ~penable;
  assign err_nxt   = psel & ~penable & ~mapped;

  logic [7:0]  mode_r, mode_nxt;
  logic        idle_r, idle_nxt;
  logic [7:0]  iropt_r, iropt_nxt;
  logic [7:0]  blank_r, blank_nxt;
  logic        share_r, share_nxt;
  logic [`IRQ_WIDTH-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic [`IRQ_WIDTH-1:0] events;

  always_comb begin
    mode_nxt  = mode_r;
    iropt_nxt = iropt_r;
    blank_nxt = blank_r;
    share_nxt = share_r;
    mask_nxt  = mask_r;
    stat_nxt  = stat_r;
    // Reserved bits are dropped on write, so they always read back as zero
    if (wr && mapped) begin
      case (idx)
        `REG_IDX_MODE:     mode_nxt  = pwdata[7:0] & `MODE_WMASK & ~(8'h01 << `MODE_IDLE_BIT);
        `REG_IDX_IROPT:    iropt_nxt = pwdata[7:0] & `IROPT_WMASK;
        `REG_IDX_BLANK:    blank_nxt = pwdata[7:0];
        `REG_IDX_SHARE:    share_nxt = pwdata[0];
        `REG_IDX_IRQ_MASK: mask_nxt  = pwdata[`IRQ_WIDTH-1:0];
        `REG_IDX_IRQ_STAT: stat_nxt  = stat_r & ~pwdata[`IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
    // Set wins over a simultaneous write-one clear
    stat_nxt = stat_nxt | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r  <= `MODE_RESET;
      iropt_r <= `IROPT_RESET;
      blank_r <= `BLANK_RESET;
      share_r <= 1'b0;
      mask_r  <= '0;
      stat_r  <= '0;
    end else begin
      mode_r  <= mode_nxt;
      iropt_r <= iropt_nxt;
      blank_r <= blank_nxt;
      share_r <= share_nxt;
      mask_r  <= mask_nxt;
      stat_r  <= stat_nxt;
    end
  end

  // Standby-domain bit survives main resets
  always_comb begin
    idle_nxt = idle_r;
    if (wr && mapped && idx == `REG_IDX_MODE) begin
      idle_nxt = pwdata[`MODE_IDLE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge standby_por_n) begin
    if (!standby_por_n) begin
      idle_r <= 1'b0;
    end else begin
      idle_r <= idle_nxt;
    end
  end

  // Mode decode; reserved codes fall back to standard
  ir_mode_e mode_dec;
  always_comb begin
    case (iropt_r[`IROPT_MODE_LSB +: 3])
      IR_MODE_IRDA: mode_dec = IR_MODE_IRDA;
      IR_MODE_ASK:  mode_dec = IR_MODE_ASK;
      default:      mode_dec = IR_MODE_STD;
    endcase
  end

  // Half-duplex blanking
  typedef enum logic [1:0] {BL_IDLE, BL_ACTIVE, BL_HOLD} blank_state_e;
  blank_state_e bl_r, bl_nxt;
  logic [15:0]  step_r, step_nxt;
  logic [7:0]   left_r, left_nxt;
  logic         half_dup, activity, blanked;
  assign half_dup = iropt_r[`IROPT_DUPLEX_BIT];
  assign activity = core_in.tx_active | core_in.rx_active;
  // Blanking starts only on transmit; receive activity alone never blanks
  // The hold runs blank_r steps of STEP_CYCLES clocks to cover the echo tail

  always_comb begin
    bl_nxt   = bl_r;
    step_nxt = step_r;
    left_nxt = left_r;
    case (bl_r)
      BL_IDLE: begin
        if (half_dup && core_in.tx_active) begin
          bl_nxt = BL_ACTIVE;
        end
      end
      BL_ACTIVE: begin
        if (!activity) begin
          if (blank_r == 8'h00) begin
            bl_nxt = BL_IDLE;
          end else begin
            bl_nxt   = BL_HOLD;
            left_nxt = blank_r;
            step_nxt = 16'(STEP_CYCLES - 1);
          end
        end
      end
      BL_HOLD: begin
        if (core_in.tx_active) begin
          bl_nxt = BL_ACTIVE;
        end else if (step_r != 16'h0000) begin
          step_nxt = step_r - 16'h0001;
        end else if (left_r == 8'h01) begin
          bl_nxt = BL_IDLE;
        end else begin
          left_nxt = left_r - 8'h01;
          step_nxt = 16'(STEP_CYCLES - 1);
        end
      end
      default: bl_nxt = BL_IDLE;
    endcase
    if (!half_dup) begin
      bl_nxt = BL_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bl_r   <= BL_IDLE;
      step_r <= '0;
      left_r <= '0;
    end else begin
      bl_r   <= bl_nxt;
      step_r <= step_nxt;
      left_r <= left_nxt;
    end
  end

  assign blanked = half_dup && (core_in.tx_active || bl_r != BL_IDLE);

  // Pins
  logic      alt, rx_raw, rx_pol, tx_pol_line, tx_drive;
  logic      rx_nxt, rx_prev_r;
  line_out_s pins_nxt;
  // Alternate pins have no idle-level option and are driven whenever option bit 6 selects them
  // Receive reads zero while blanked, so the core sees a quiet line
  assign alt    = iropt_r[`IROPT_MUX_BIT];
  assign rx_raw = alt ? pins_in.alt_rx : pins_in.rx;
  assign rx_pol = rx_raw ^ iropt_r[`IROPT_RXPOL_BIT];
  assign rx_nxt = blanked ? 1'b0 : rx_pol;

  always_comb begin
    tx_pol_line = core_in.tx ^ iropt_r[`IROPT_TXPOL_BIT];
    tx_drive    = !(idle_r && !core_in.tx_active);
    pins_nxt    = '0;
    if (alt) begin
      pins_nxt.alt_tx    = tx_pol_line;
      pins_nxt.alt_tx_oe = 1'b1;
    end else begin
      pins_nxt.tx    = (tx_drive && core_in.tx_active) ? tx_pol_line : 1'b0;
      pins_nxt.tx_oe = tx_drive;
    end
  end

  // Interrupt sharing
  // Sharing puts either cause on both lines; software leaves one unit lineless
  logic [1:0] first_nxt, second_nxt;
  logic       any_unit;
  assign any_unit   = first_unit_irq_in | (|core_in.irq);
  assign first_nxt  = share_r ? {2{any_unit}} : {1'b0, first_unit_irq_in};
  assign second_nxt = share_r ? {2{any_unit}} : core_in.irq;
  assign events[`IRQ_RX_BLANKED_BIT] = blanked && (rx_pol != rx_prev_r);
  assign events[`IRQ_BLANK_END_BIT]  = (bl_r != BL_IDLE) && (bl_nxt == BL_IDLE);

  // Taken from next state so the line follows a set or a clear on the same edge
  logic       irq_nxt;
  assign irq_nxt = |(stat_nxt & mask_nxt);

  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    // Fetched in the setup cycle so prdata stands while pready is high
    if (psel && !penable && !pwrite && mapped) begin
      case (idx)
        `REG_IDX_MODE:     rd_nxt = {24'h0, mode_r | ({7'h00, idle_r} << `MODE_IDLE_BIT)};
        `REG_IDX_IROPT:    rd_nxt = {24'h0, iropt_r};
        `REG_IDX_BLANK:    rd_nxt = {24'h0, blank_r};
        `REG_IDX_SHARE:    rd_nxt = {31'h0, share_r};
        `REG_IDX_IRQ_STAT: rd_nxt = {30'h0, stat_r};
        `REG_IDX_IRQ_MASK: rd_nxt = {30'h0, mask_r};
        `REG_IDX_STATUS:   rd_nxt = {29'h0, blanked, bl_r};
        default:           rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready              <= 1'b0;
      prdata              <= '0;
      pslverr             <= 1'b0;
      pins_out            <= '0;
      core_rx_out         <= 1'b0;
      rx_prev_r           <= 1'b0;
      midi_enable         <= 1'b0;
      high_speed_enable   <= 1'b0;
      ir_mode             <= IR_MODE_STD;
      first_unit_irq_out  <= '0;
      second_unit_irq_out <= '0;
      irq                 <= 1'b0;
    end else begin
      pready              <= ready_nxt;
      prdata              <= rd_nxt;
      pslverr             <= err_nxt;
      pins_out            <= pins_nxt;
      core_rx_out         <= rx_nxt;
      rx_prev_r           <= rx_pol;
      midi_enable         <= mode_r[`MODE_MIDI_BIT];
      high_speed_enable   <= mode_r[`MODE_HS_BIT];
      ir_mode             <= mode_dec;
      first_unit_irq_out  <= first_nxt;
      second_unit_irq_out <= second_nxt;
      irq                 <= irq_nxt;
    end
  end
endmodule : serial2_infrared_config

/* File: bench/ir_transceiver_model.sv */
// Purpose: far-side infrared transceiver for the second serial unit
// Assumes: light arriving from the remote station is given by the bench
// Notes:   own transmitted light is echoed into the receiver
`timescale 1ns/10ps
module ir_transceiver_model
  import serial2_ir_pkg::*;
(
  input  wire logic      light_in,
  input  wire line_out_s pins_out,
  output line_in_s       pins_in
);
  // The echo is the hazard that half-duplex blanking must hide
  assign pins_in.rx     = light_in | (pins_out.tx_oe & pins_out.tx);
  assign pins_in.alt_rx = light_in | (pins_out.alt_tx_oe & pins_out.alt_tx);
endmodule : ir_transceiver_model

/* File: bench/serial2_ir_monitor.sv */
// Purpose: port checker for the second serial infrared configuration block
// Assumes: APB answers in the access cycle
// Notes:   bound to every instance of the block
`timescale 1ns/10ps
module serial2_ir_monitor
  import serial2_ir_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire uart_side_s  core_in,
  input wire logic        first_unit_irq_in,
  input wire logic        midi_enable,
  input wire logic        high_speed_enable,
  input wire ir_mode_e    ir_mode,
  input wire logic [1:0]  first_unit_irq_out,
  input wire logic [1:0]  second_unit_irq_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr = psel && penable && pready && pwrite;
  ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready in access cycle");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  misalign_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr) else $error("misaligned not refused");
  err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not 0");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  mode_legal_a: assert property (ir_mode inside {IR_MODE_STD, IR_MODE_IRDA, IR_MODE_ASK}) else $error("bad mode");
  midi_write_a: assert property (wr && paddr == 12'h3C0 |-> ##2 midi_enable == $past(pwdata[0], 2))
    else $error("midi enable not written");
  speed_write_a: assert property (wr && paddr == 12'h3C0 |-> ##2 high_speed_enable == $past(pwdata[1], 2))
    else $error("high speed not written");
  ir_mode_write_a: assert property (wr && paddr == 12'h3C4 |-> ##2
    ir_mode == ($past(pwdata[5:3], 2) > 3'h2 ? 3'h0 : $past(pwdata[5:3], 2))) else $error("mode not written");
  first_irq_a: assert property (first_unit_irq_in |=> first_unit_irq_out[0]) else $error("first irq lost");
  second_irq_a: assert property (core_in.irq[0] |=> second_unit_irq_out[0]) else $error("second irq lost");
  cover property (pready && pslverr);
  cover property (second_unit_irq_out == 2'h3);
  cover property (ir_mode == IR_MODE_ASK);
endmodule : serial2_ir_monitor
bind serial2_infrared_config serial2_ir_monitor u_serial2_ir_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .core_in(core_in), .first_unit_irq_in(first_unit_irq_in),
  .midi_enable(midi_enable), .high_speed_enable(high_speed_enable), .ir_mode(ir_mode),
  .first_unit_irq_out(first_unit_irq_out), .second_unit_irq_out(second_unit_irq_out));

/* File: bench/tb_serial2_infrared_config.sv */
// Purpose: self-checking bench for the second serial infrared configuration block
// Assumes: blanking step shortened to 4 clocks
// Notes:   reads are checked from an expectation queue
`timescale 1ns/10ps
module tb_serial2_infrared_config;
  import serial2_ir_pkg::*;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        standby_por_n = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic        pready, pslverr, core_rx_out, midi_enable, high_speed_enable, irq;
  logic [31:0] prdata;
  uart_side_s  core_in = '0;
  logic        first_unit_irq_in = 0;
  logic        light = 0;
  line_in_s    pins_in;
  line_out_s   pins_out;
  ir_mode_e    ir_mode;
  logic [1:0]  first_unit_irq_out, second_unit_irq_out;
  logic [32:0] exp_q[$];
  int          fail_count = 0;
  int          cmp_count = 0;
  always #12.5 pclk = ~pclk;
  serial2_infrared_config #(.STEP_CYCLES(4)) u_serial2_infrared_config (.pclk(pclk), .presetn(presetn),
    .standby_por_n(standby_por_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .core_in(core_in),
    .first_unit_irq_in(first_unit_irq_in), .pins_in(pins_in), .pins_out(pins_out), .core_rx_out(core_rx_out),
    .midi_enable(midi_enable), .high_speed_enable(high_speed_enable), .ir_mode(ir_mode),
    .first_unit_irq_out(first_unit_irq_out), .second_unit_irq_out(second_unit_irq_out), .irq(irq));
  ir_transceiver_model u_ir_transceiver_model (.light_in(light), .pins_out(pins_out), .pins_in(pins_in));
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
    int n;
    n = 0;
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    if (!wr) exp_q.push_back(exp);
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      fail_count++;
      print_verdict();
    end
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask : apb
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) check("read without note", 33'h0, 33'h1FFFFFFFF);
      else check("apb read", {pslverr, prdata}, exp_q.pop_front());
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  initial begin
    logic [31:0] v;
    void'($urandom(32'h56BD));
    tick(2);
    presetn <= 1; standby_por_n <= 1;
    tick(1);
    apb(0, 12'h3C0, 0, 33'h0);
    apb(0, 12'h3C4, 0, 33'h2);
    apb(0, 12'h3C8, 0, 33'h3);
    apb(0, 12'h3DC, 0, {1'b1, 32'h0});
    v = $urandom & 32'h23;
    apb(1, 12'h3C0, v, 0);
    apb(0, 12'h3C0, 0, {1'b0, v});
    check("midi", 33'(midi_enable), 33'(v[0]));
    check("speed", 33'(high_speed_enable), 33'(v[1]));
    apb(1, 12'h3C0, 32'h20, 0);
    tick(2);
    check("idle oe", 33'(pins_out.tx_oe), 33'h0);
    presetn <= 0; tick(1); presetn <= 1; tick(1);
    apb(0, 12'h3C0, 0, 33'h20);
    standby_por_n <= 0; tick(1); standby_por_n <= 1; tick(1);
    apb(0, 12'h3C0, 0, 33'h0);
    check("idle drive", {31'h0, pins_out.tx_oe, pins_out.tx}, 33'h2);
    for (int m = 0; m < 8; m++) begin
      apb(1, 12'h3C4, m << 3, 0);
      tick(2);
      check("ir mode", 33'(ir_mode), (m > 2) ? 33'h0 : 33'(m));
    end
    apb(1, 12'h3C4, 32'h01, 0);
    tick(3);
    check("rx active low", 33'(core_rx_out), 33'h1);
    v = $urandom & 32'h1;
    core_in.tx_active <= 1; core_in.tx <= v[0]; light <= 1;
    for (int k = 0; k < 3; k++) begin
      apb(1, 12'h3C4, (k == 2) ? 32'h40 : k << 1, 0);
      tick(2);
      if (k == 0) check("full duplex rx", 33'(core_rx_out), 33'h1);
      if (k < 2) check("tx polarity", 33'(pins_out.tx), 33'(v[0] ^ k[0]));
      else check("alt tx", 33'(pins_out.alt_tx), 33'(v[0]));
    end
    core_in.tx_active <= 0;
    apb(1, 12'h3C4, 32'h04, 0);
    apb(1, 12'h3C8, 32'h02, 0);
    for (int z = 0; z < 2; z++) begin
      core_in.tx_active <= 1; tick(5);
      check("blank in tx", 33'(core_rx_out), 33'h0);
      core_in.tx_active <= 0; tick(9);
      check("blank hold", 33'(core_rx_out), (z == 0) ? 33'h0 : 33'h1);
      tick(2);
      check("blank end", 33'(core_rx_out), 33'h1);
      check("masked irq", 33'(irq), 33'h0);
      apb(1, 12'h3C8, 32'h0, 0);
    end
    apb(1, 12'h3D4, 32'h2, 0);
    tick(1);
    check("irq on", 33'(irq), 33'h1);
    apb(1, 12'h3D0, 32'h3, 0);
    tick(1);
    check("irq clear", 33'(irq), 33'h0);
    apb(1, 12'h3D4, 32'h1, 0);
    core_in.tx <= 0; core_in.tx_active <= 1; tick(2);
    light <= 0; tick(2);
    check("rx edge irq", 33'(irq), 33'h1);
    core_in.tx_active <= 0; light <= 1;
    apb(1, 12'h3D0, 32'h3, 0);
    apb(1, 12'h3CC, 32'h1, 0);
    first_unit_irq_in <= 1; tick(2);
    check("shared lines", {29'h0, first_unit_irq_out, second_unit_irq_out}, 33'hF);
    apb(1, 12'h3CC, 32'h0, 0);
    tick(1);
    check("split lines", {29'h0, first_unit_irq_out, second_unit_irq_out}, 33'h4);
    first_unit_irq_in <= 0; core_in.irq <= 2'h1; tick(2);
    check("second unit lines", {29'h0, first_unit_irq_out, second_unit_irq_out}, 33'h1);
    apb(1, 12'h3CC, 32'h1, 0);
    tick(1);
    check("shared second", {29'h0, first_unit_irq_out, second_unit_irq_out}, 33'hF);
    print_verdict();
  end
endmodule : tb_serial2_infrared_config
